// [shared/apx_defs.svh]
`ifndef APX_DEFS_SVH
`define APX_DEFS_SVH

// Bit clock ratio codes of the port control field
`define APX_RATIO_32 2'h0
`define APX_RATIO_64 2'h1
`define APX_RATIO_128 2'h2
// Bit clocks per sample period
`define APX_BCLK_32 8'h20
`define APX_BCLK_64 8'h40
`define APX_BCLK_128 8'h80
// Sample widths per format
`define APX_WIDTH_I2S 6'h12
`define APX_WIDTH_LJ 6'h14
// Channel slot word: 20 bits, MSB at 19
`define APX_SLOT_MSB 5'h13
`define APX_WORD_W 40
// First data bit offset from the frame edge
`define APX_OFS_I2S 7'h01
`define APX_OFS_LJ 7'h00
// Marks a slot position with no data bit
`define APX_NO_BIT 6'h3F
// Format select codes
`define APX_FMT_I2S 1'h0
`define APX_FMT_LJ 1'h1

`endif

// [shared/apx_pkg.sv]
package apx_pkg;
    // Port sequencer states, one-hot
    typedef enum logic [1:0] {
        APX_IDLE = 2'b01,
        APX_RUN = 2'b10
    } apx_state_t;

    // Stereo pair as carried through the buffers
    typedef logic [39:0] apx_pair_t;
endpackage

// [hw/apx_buf2.sv]
// Two-entry buffer, valid/ready on both sides
module apx_buf2 #(
    parameter int W = 40
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem_r [2];
    logic [W-1:0] mem_nxt [2];
    logic wr_r, wr_nxt, rd_r, rd_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Honest full and empty from the fill count
    assign in_ready_o = (cnt_r != 2'h2);
    assign out_valid_o = (cnt_r != 2'h0);
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Pointer and storage next values
    always_comb begin
        mem_nxt = mem_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wr_r] = in_data_i;
            wr_nxt = ~wr_r;
        end
        if (pop) begin
            rd_nxt = ~rd_r;
        end
        case ({push, pop})
            2'b10: cnt_nxt = cnt_r + 2'h1;
            2'b01: cnt_nxt = cnt_r - 2'h1;
            default: cnt_nxt = cnt_r;
        endcase
    end

    // Registers; storage needs no reset
    always_ff @(posedge clk_i) begin
        mem_r <= mem_nxt;
        if (sys_rst_i) begin
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// [hw/apx_port.sv]
// Summary of operation
// - The core reads received and writes outgoing stereo sample pairs through direct ports.
// - Receive and transmit run at the same time on every frame.
// - The port always generates the bit clock and frame select itself.
// - One format select governs both the input and the output direction.
// - Input and output run at the single sample rate shared with the DAC.
// - The I2S-style format carries 18-bit samples, normally at 64 bit clocks per frame.
// - The left-justified format carries 20-bit samples, normally at 128 bit clocks per frame.
// - The generated bit clock times both serial directions.
// - Frame select is an output completing one cycle per sample period.
// - The sample rate comes from a core-programmed divider value, not a fixed one.
// - Frame select and serial out change only at bit clock falling edges.
// - Serial in is captured at bit clock rising edges.
// - A two-bit control field picks 32, 64 or 128 bit clocks per sample.
`include "apx_defs.svh"

module apx_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Core configuration
    input wire logic port_enable_i,
    input wire logic format_i,
    input wire logic [1:0] aux_port_control_i,
    input wire logic [7:0] half_period_i,
    // Transmit pairs from the core
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [19:0] tx_left_i,
    input wire logic [19:0] tx_right_i,
    // Received pairs to the core
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic [19:0] rx_left_o,
    output logic [19:0] rx_right_o,
    // Status pulses and level
    output logic rx_overrun_o,
    output logic tx_underrun_o,
    output logic port_active_o,
    // Audio pins
    output logic aux_bit_clock_o,
    output logic aux_frame_select_o,
    output logic aux_serial_out_o,
    input wire logic aux_serial_in_i
);
    import apx_pkg::*;

    // Bit clocks per sample for a control code; code 3 falls back to 64
    function automatic logic [7:0] ratio_of(input logic [1:0] code);
        unique case (code)
            `APX_RATIO_32: ratio_of = `APX_BCLK_32;
            `APX_RATIO_128: ratio_of = `APX_BCLK_128;
            default: ratio_of = `APX_BCLK_64;
        endcase
    endfunction

    // Data bit index within a slot, or no-bit marker
    function automatic logic [5:0] bit_index(input logic [6:0] pos, input logic fmt);
        logic [6:0] ofs;
        logic [6:0] idx;
        logic [5:0] width;
        ofs = (fmt == `APX_FMT_LJ) ? `APX_OFS_LJ : `APX_OFS_I2S;
        width = (fmt == `APX_FMT_LJ) ? `APX_WIDTH_LJ : `APX_WIDTH_I2S;
        idx = pos - ofs;
        if (pos < ofs || idx >= {1'b0, width}) begin
            bit_index = `APX_NO_BIT;
        end else begin
            bit_index = idx[5:0];
        end
    endfunction

    // Slot position of a frame bit: channel flag and offset in slot
    function automatic logic [7:0] slot_of(input logic [6:0] bitn, input logic [7:0] ratio);
        logic [7:0] half;
        logic [7:0] b;
        half = ratio >> 1;
        b = {1'b0, bitn};
        if (b >= half) begin
            slot_of = {1'b1, 7'(b - half)};
        end else begin
            slot_of = {1'b0, bitn};
        end
    endfunction

    apx_state_t state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic bclk_r, bclk_nxt;
    logic [6:0] bit_r, bit_nxt;
    logic fmt_r, fmt_nxt;
    logic [1:0] ctl_r, ctl_nxt;
    logic lr_r, lr_nxt;
    logic dout_r, dout_nxt;
    logic armed_r, armed_nxt;
    logic ovr_r, ovr_nxt;
    logic und_r, und_nxt;
    logic [39:0] tx_word_r, tx_word_nxt;
    logic [39:0] rx_word_r, rx_word_nxt;
    logic sin_s1_r, sin_s2_r;
    logic tick, fall_tick, rise_tick, wrap;
    logic [7:0] ratio, cur_slot, new_slot;
    logic [6:0] last_bit, bit_new;
    logic [5:0] cur_idx, new_idx;
    logic fmt_new;
    logic [39:0] word_src;
    logic [4:0] sel;
    logic tx_q_valid, tx_q_pop;
    apx_pair_t tx_q_data;
    logic rx_q_push, rx_q_ready;
    apx_pair_t rx_q_data;

    // Core writes pairs into a two-entry queue, drained once per frame
    // core write path
    apx_buf2 #(.W(`APX_WORD_W)) u_tx_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i({tx_left_i, tx_right_i}),
        .out_valid_o(tx_q_valid),
        .out_ready_i(tx_q_pop),
        .out_data_o(tx_q_data)
    );

    // Received pairs wait here; a pair arriving with both entries full is dropped and flagged as overrun
    // core read path
    apx_buf2 #(.W(`APX_WORD_W)) u_rx_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(rx_q_push),
        .in_ready_o(rx_q_ready),
        .in_data_i(rx_q_data),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o({rx_left_o, rx_right_o})
    );

    // Pin input synchroniser; only the second stage is read
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sin_s1_r <= 1'b0;
            sin_s2_r <= 1'b0;
        end else begin
            sin_s1_r <= aux_serial_in_i;
            sin_s2_r <= sin_s1_r;
        end
    end

    // Divider ticks; one half bit clock per tick
    // programmed rate divider
    assign tick = (state_r == APX_RUN) && ({1'b0, cnt_r} + 9'h001 >= {1'b0, half_period_i});
    assign fall_tick = tick & bclk_r;
    assign rise_tick = tick & ~bclk_r;
    assign ratio = ratio_of(ctl_r);
    assign last_bit = 7'(ratio - 8'h01);
    assign wrap = (bit_r == last_bit);
    assign bit_new = wrap ? 7'h00 : bit_r + 7'h01;
    // Format for the coming frame is taken at the frame edge
    assign fmt_new = wrap ? format_i : fmt_r;
    assign cur_slot = slot_of(bit_r, ratio);
    assign new_slot = slot_of(bit_new, ratio_of(wrap ? aux_port_control_i : ctl_r));
    assign cur_idx = bit_index(cur_slot[6:0], fmt_r);
    assign new_idx = bit_index(new_slot[6:0], fmt_new);
    assign word_src = wrap ? (tx_q_valid ? tx_q_data : 40'h0) : tx_word_r;
    assign sel = `APX_SLOT_MSB - new_idx[4:0];
    assign tx_q_pop = fall_tick & wrap & (state_nxt == APX_RUN);
    assign rx_q_push = fall_tick & wrap & armed_r;
    assign rx_q_data = rx_word_r;

    // Sequencer and serial datapath next values
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        bclk_nxt = bclk_r;
        bit_nxt = bit_r;
        fmt_nxt = fmt_r;
        ctl_nxt = ctl_r;
        lr_nxt = lr_r;
        dout_nxt = dout_r;
        armed_nxt = armed_r;
        ovr_nxt = 1'b0;
        und_nxt = 1'b0;
        tx_word_nxt = tx_word_r;
        rx_word_nxt = rx_word_r;
        unique case (state_r)
            APX_IDLE: begin
                // Park with the clock high so the first tick is a fall
                fmt_nxt = format_i;
                ctl_nxt = aux_port_control_i;
                bit_nxt = 7'(ratio_of(aux_port_control_i) - 8'h01);
                bclk_nxt = 1'b1;
                cnt_nxt = 8'h00;
                armed_nxt = 1'b0;
                lr_nxt = 1'b0;
                dout_nxt = 1'b0;
                if (port_enable_i) begin
                    state_nxt = APX_RUN;
                end
            end
            APX_RUN: begin
                cnt_nxt = tick ? 8'h00 : cnt_r + 8'h01;
                if (tick) begin
                    bclk_nxt = ~bclk_r;
                end
                if (rise_tick) begin
                    if (cur_idx != `APX_NO_BIT) begin
                        // Left slot sits in the upper half of the pair word
                        rx_word_nxt[6'(`APX_SLOT_MSB) + (cur_slot[7] ? 6'h00 : `APX_WIDTH_LJ)
                            - cur_idx] = sin_s2_r;
                    end
                end
                if (fall_tick) begin
                    bit_nxt = bit_new;
                    tx_word_nxt = word_src;
                    if (wrap) begin
                        fmt_nxt = format_i;
                        ctl_nxt = aux_port_control_i;
                        armed_nxt = 1'b1;
                        rx_word_nxt = 40'h0;
                        ovr_nxt = armed_r & ~rx_q_ready;
                        und_nxt = ~tx_q_valid;
                        if (!port_enable_i) begin
                            state_nxt = APX_IDLE;
                        end
                    end
                    // one frame select cycle per sample
                    // left-justified: left slot high
                    // Park low on stop so idle never moves frame select without a fall
                    lr_nxt = (state_nxt == APX_IDLE) ? 1'b0 : (new_slot[7] ^ fmt_new);
                    if (new_idx == `APX_NO_BIT || state_nxt == APX_IDLE) begin
                        dout_nxt = 1'b0;
                    end else if (new_slot[7]) begin
                        dout_nxt = word_src[sel];
                    end else begin
                        dout_nxt = word_src[6'(sel) + 6'h14];
                    end
                end
            end
        endcase
    end

    // Sequencer registers
    // single rate for both directions
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_r <= APX_IDLE;
            cnt_r <= 8'h00;
            bclk_r <= 1'b0;
            bit_r <= 7'h00;
            fmt_r <= `APX_FMT_I2S;
            ctl_r <= `APX_RATIO_64;
            lr_r <= 1'b0;
            dout_r <= 1'b0;
            armed_r <= 1'b0;
            ovr_r <= 1'b0;
            und_r <= 1'b0;
            tx_word_r <= 40'h0;
            rx_word_r <= 40'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bclk_r <= bclk_nxt;
            bit_r <= bit_nxt;
            fmt_r <= fmt_nxt;
            ctl_r <= ctl_nxt;
            lr_r <= lr_nxt;
            dout_r <= dout_nxt;
            armed_r <= armed_nxt;
            ovr_r <= ovr_nxt;
            und_r <= und_nxt;
            tx_word_r <= tx_word_nxt;
            rx_word_r <= rx_word_nxt;
        end
    end

    // Pin and status outputs, all from flops; idle clock is held low
    assign aux_bit_clock_o = bclk_r & (state_r == APX_RUN);
    assign aux_frame_select_o = lr_r;
    assign aux_serial_out_o = dout_r;
    assign rx_overrun_o = ovr_r;
    assign tx_underrun_o = und_r;
    assign port_active_o = (state_r == APX_RUN);
endmodule

// [test/apx_port_assertions.sv]
module apx_port_assertions (
    // Clock, reset and control
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] aux_port_control_i,
    input wire logic [7:0] half_period_i,
    // Core receive side
    input wire logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [19:0] rx_left_o,
    input wire logic rx_overrun_o,
    input wire logic port_active_o,
    // Audio pins
    input wire logic aux_bit_clock_o,
    input wire logic aux_frame_select_o,
    input wire logic aux_serial_out_o
);
    logic [15:0] gap_r;
    logic [15:0] bits;
    logic seen_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Code 3 runs like code 1
    assign bits = (aux_port_control_i == 2'h0) ? 16'h0020 :
        (aux_port_control_i == 2'h2) ? 16'h0080 : 16'h0040;
    // Cycles since the last frame select edge; first edge after start is partial
    always_ff @(posedge clk_i) begin
        gap_r <= ($changed(aux_frame_select_o) || !port_active_o) ? 16'h0001 : gap_r + 16'h0001;
        seen_r <= port_active_o && (seen_r || $changed(aux_frame_select_o));
    end
    property p_lr_fall; $changed(aux_frame_select_o) |-> $fell(aux_bit_clock_o); endproperty
    a_lr_fall: assert property (p_lr_fall) else $error("frame select moved off a fall");
    property p_out_fall; $changed(aux_serial_out_o) |-> $fell(aux_bit_clock_o); endproperty
    a_out_fall: assert property (p_out_fall) else $error("serial out moved off a fall");
    property p_clk_own; $rose(aux_bit_clock_o) |-> port_active_o; endproperty
    a_clk_own: assert property (p_clk_own) else $error("bit clock ran while idle");
    property p_half;
        $rose(aux_bit_clock_o) && half_period_i == 8'h04 |-> aux_bit_clock_o[*4] ##1 !aux_bit_clock_o;
    endproperty
    a_half: assert property (p_half) else $error("bit clock high phase wrong");
    property p_lr_rate;
        $changed(aux_frame_select_o) && seen_r && port_active_o |-> gap_r == bits * half_period_i;
    endproperty
    a_lr_rate: assert property (p_lr_rate) else $error("frame select period wrong");
    property p_rx_hold; rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_left_o); endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive pair not held");
    property p_ovr; rx_overrun_o |-> $past(rx_valid_o) ##1 !rx_overrun_o; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun pulse wrong");
    property p_rx_tick;
        $rose(rx_valid_o) |-> $past(aux_bit_clock_o) && !aux_bit_clock_o;
    endproperty
    a_rx_tick: assert property (p_rx_tick) else $error("receive pair off frame end");
endmodule

bind apx_port apx_port_assertions chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .aux_port_control_i(aux_port_control_i), .half_period_i(half_period_i),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_left_o(rx_left_o),
    .rx_overrun_o(rx_overrun_o), .port_active_o(port_active_o),
    .aux_bit_clock_o(aux_bit_clock_o), .aux_frame_select_o(aux_frame_select_o),
    .aux_serial_out_o(aux_serial_out_o));

// [test/apx_codec_model.sv]
module apx_codec_model (
    // Setup from the bench
    input wire logic clr_i,
    input wire logic fmt_i,
    input wire logic [7:0] bits_i,
    input wire logic [39:0] pair_i,
    // Audio pins
    input wire logic bclk_i,
    input wire logic lr_i,
    input wire logic sout_i,
    output logic sin_o,
    // Results
    output int nfr_o,
    output int pad_err_o,
    output logic [39:0] got_o [8]
);
    timeunit 1ns;
    timeprecision 100ps;
    int pos;
    int k;
    logic first;
    logic lr_q;
    // Slot bit index, negative or too large on pad positions
    function automatic int idx(int p);
        return (p % (bits_i / 2)) - (fmt_i ? 0 : 1);
    endfunction
    initial sin_o = 1'b0;
    // Fresh run
    always @(posedge clr_i) begin
        first = 1'b1;
        nfr_o = 0;
        pad_err_o = 0;
        foreach (got_o[i]) got_o[i] = '0;
    end
    always @(negedge bclk_i) begin
        #1;
        if (first || (lr_i == fmt_i && lr_q != fmt_i)) begin
            pos = 0;
            nfr_o++;
            first = 1'b0;
        end else begin
            pos++;
        end
        lr_q = lr_i;
        k = idx(pos);
        // Pads toggle so a design that keeps them shows up
        sin_o = (k >= 0 && k < (fmt_i ? 20 : 18)) ?
            (pos < bits_i / 2 ? pair_i[39-k] : pair_i[19-k]) : pos[0];
    end
    always @(posedge bclk_i) begin
        k = idx(pos);
        if (k >= 0 && k < (fmt_i ? 20 : 18)) begin
            got_o[nfr_o][pos < bits_i / 2 ? 39 - k : 19 - k] = sout_i;
        end else if (sout_i !== 1'b0) begin
            pad_err_o++;
        end
    end
endmodule

// [test/apx_port_tb.sv]
module apx_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, sys_rst_i = 1, port_enable_i = 0, format_i = 0, clr = 0;
    logic tx_valid_i = 0, rx_ready_i = 0, tx_ready_o, rx_valid_o, rx_overrun_o, tx_underrun_o;
    logic port_active_o, aux_bit_clock_o, aux_frame_select_o, aux_serial_out_o, aux_serial_in_i;
    logic [1:0] aux_port_control_i = 2'h1;
    logic [7:0] bits = 8'h40;
    logic [19:0] tx_left_i = '0, tx_right_i = '0, rx_left_o, rx_right_o;
    logic [39:0] pair = '0;
    logic [39:0] got [8];
    int n_mismatch = 0, compares = 0, n_ovr = 0, n_und = 0, nfr, pad_err;
    apx_port DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port_enable_i(port_enable_i),
        .format_i(format_i), .aux_port_control_i(aux_port_control_i), .half_period_i(8'h04),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_left_i(tx_left_i),
        .tx_right_i(tx_right_i), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
        .rx_left_o(rx_left_o), .rx_right_o(rx_right_o), .rx_overrun_o(rx_overrun_o),
        .tx_underrun_o(tx_underrun_o), .port_active_o(port_active_o),
        .aux_bit_clock_o(aux_bit_clock_o), .aux_frame_select_o(aux_frame_select_o),
        .aux_serial_out_o(aux_serial_out_o), .aux_serial_in_i(aux_serial_in_i));
    apx_codec_model u_codec (.clr_i(clr), .fmt_i(format_i), .bits_i(bits), .pair_i(pair),
        .bclk_i(aux_bit_clock_o), .lr_i(aux_frame_select_o), .sout_i(aux_serial_out_o),
        .sin_o(aux_serial_in_i), .nfr_o(nfr), .pad_err_o(pad_err), .got_o(got));
    initial forever #5 clk_i = ~clk_i;
    // Status pulse counters
    always @(posedge clk_i) begin
        n_ovr += (rx_overrun_o === 1'b1);
        n_und += (tx_underrun_o === 1'b1);
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Bits a slot can carry; the rest arrive as zero
    function automatic logic [39:0] cut(logic [39:0] v, logic f, int b);
        int n;
        n = f ? 20 : 18;
        if (n > b / 2 - (f ? 0 : 1)) n = b / 2 - (f ? 0 : 1);
        return v & ~{20'hFFFFF >> n, 20'hFFFFF >> n};
    endfunction
    task automatic t_reset();
        check({aux_bit_clock_o, aux_frame_select_o, aux_serial_out_o, rx_valid_o, rx_overrun_o,
            tx_underrun_o, port_active_o, tx_ready_o}, 40'h01);
    endtask
    // Two queued words, then underrun; receive fills and overruns
    task automatic t_frames(logic f, logic [1:0] c, int b, logic [39:0] a, logic [39:0] d);
        int t;
        format_i = f;
        aux_port_control_i = c;
        bits = b[7:0];
        pair = a ^ d;
        clr = 1;
        tx_left_i = a[39:20];
        tx_right_i = a[19:0];
        tx_valid_i = 1;
        step(1);
        clr = 0;
        tx_left_i = d[39:20];
        tx_right_i = d[19:0];
        step(1);
        tx_valid_i = 0;
        check(tx_ready_o, 0);
        n_ovr = 0;
        n_und = 0;
        port_enable_i = 1;
        for (t = 0; t < 9000 && nfr < 5; t++) step(1);
        port_enable_i = 0;
        check(nfr >= 5, 1);
        step(4);
        check(got[1], cut(a, f, b));
        check(got[2], cut(d, f, b));
        check(got[3], 0);
        check(pad_err, 0);
        check({n_ovr > 0, n_und > 0}, 3);
        check({rx_left_o, rx_right_o}, cut(a ^ d, f, b));
        rx_ready_i = 1;
        step(1);
        check(rx_valid_o, 1);
        check({rx_left_o, rx_right_o}, cut(a ^ d, f, b));
        step(1);
        rx_ready_i = 0;
        for (t = 0; t < 3000 && port_active_o !== 1'b0; t++) step(1);
        // The closing frame lands in the queue emptied above
        check({port_active_o, rx_valid_o}, 1);
        check({rx_left_o, rx_right_o}, cut(a ^ d, f, b));
        rx_ready_i = 1;
        step(1);
        rx_ready_i = 0;
        check(rx_valid_o, 0);
        step(2);
    endtask
    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        step(2);
        sys_rst_i = 0;
        t_reset();
        t_frames(0, 2'h1, 64, 40'hA5C3F_5A3C1, 40'h12345_FEDCB);
        t_frames(1, 2'h2, 128, 40'hF0F0F_80001, 40'h3C3C3_7FFFE);
        t_frames(0, 2'h0, 32, 40'h9AB9C_6543F, 40'h55555_AAAAA);
        t_frames(1, 2'h3, 64, 40'h80001_C0003, 40'h7E7E7_18181);
        complete_run();
    end
endmodule
